//--- rtl/chw_pkg.sv
// Package for the core halt, hold and wait control block.
// Assumes one 250 MHz clock and an AXI4-Lite register port.
package chw_pkg;
  localparam logic [7:0] CHW_STATUS_OFF = 8'h00;
  localparam logic [7:0] CHW_CTRL_OFF = 8'h04;
  localparam logic [7:0] CHW_STATE_OFF = 8'h08;
  localparam logic [15:0] CHW_STATUS_RST = 16'h004c;
  localparam int CHW_IE_BIT = 15;
  localparam int CHW_IP_BIT = 14;
  localparam int CHW_CTRL_EMU_BIT = 0;
  localparam int CHW_CTRL_HALT_BIT = 1;
  localparam logic [1:0] CHW_RESP_OKAY = 2'b00;
  localparam logic [1:0] CHW_RESP_SLVERR = 2'b10;
  localparam int CHW_SLEEP_INSTR_CYCLES = 3;
  localparam logic [1:0] CHW_SLEEP_LAST = 2'h2;
  localparam logic [1:0] CHW_WAIT_PHASE = 2'h2;

  typedef enum logic [1:0] {CHW_INSTR_NONE, CHW_INSTR_SLEEP, CHW_INSTR_DEEP} chw_instr_t;

  typedef struct packed {
    logic bus_grant_ack_n;
    logic sleep_ack_n;
    logic irq_ack_n;
    logic irq_done_n;
  } chw_hs_t;

  typedef struct packed {
    logic ibus_oe;
    logic xybus_oe;
    logic addr_ctl_oe;
  } chw_bus_oe_t;
endpackage

//--- rtl/chw_core_control.sv
// Core suspend and resume control: sleep, deep sleep, hold, halt, wait states, interrupt flags.
// Assumes pins are synchronous to CLK_IN; registers over AXI4-Lite, one write and one read at a time.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module chw_core_control
(
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic SLEEP_REQUEST_IN,
  input wire logic EXT_IRQ_N_IN,
  input wire logic BUS_REQ_N_IN,
  input wire logic WAIT_RELEASE_N_IN,
  input wire logic INSTR_SLEEP_IN,
  input wire logic INSTR_DEEP_IN,
  input wire logic INSTR_COND_IN,
  input wire logic RTI_DONE_IN,
  output logic CYCLE_CLOCK_OUT,
  output logic CYCLE_EN_OUT,
  output logic BUS_SWITCH_CLOCK_EN_OUT,
  output logic XFER_CLOCK_EN_OUT,
  output logic ALL_CLOCK_EN_OUT,
  output logic EXEC_EN_OUT,
  output logic SLEEP_ACK_N_OUT,
  output logic IRQ_ACK_N_OUT,
  output logic IRQ_DONE_N_OUT,
  output logic BUS_GRANT_ACK_N_OUT,
  output logic IBUS_OE_OUT,
  output logic XYBUS_OE_OUT,
  output logic ADDR_CTL_OE_OUT,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  typedef enum logic [2:0] {ST_RUN, ST_SLEEP_PEND, ST_SLEEP, ST_DEEP, ST_HOLD_PEND, ST_HOLD, ST_HALT} chw_state_t;

  chw_state_t state_r, state_nxt;
  logic phase_r;
  logic [1:0] edge_cnt_r;
  logic [1:0] sleep_cnt_r;
  chw_pkg::chw_instr_t sleep_kind_r;
  logic sleep_pin_d_r, irq_pin_d_r;
  logic irq_edge_r;
  logic [15:0] status_r;
  logic emu_r, halt_req_r;
  chw_pkg::chw_hs_t hs_r;
  chw_pkg::chw_bus_oe_t oe_r;
  logic ack_active_r;
  logic wake_irq_r;
  logic [7:0] awaddr_r;
  logic aw_held_r, w_held_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;

  // Cycle boundary: a cycle of two input clocks, held while wait is pending
  // Second edge of a cycle is the one that would close it; the counter reads one there
  wire stretch = (edge_cnt_r == (chw_pkg::CHW_WAIT_PHASE - 2'h1)) && WAIT_RELEASE_N_IN;
  wire clk_run = (state_r != ST_SLEEP) && (state_r != ST_DEEP);
  wire cycle_end = clk_run && phase_r && !stretch;
  wire cycle_start = cycle_end;
  wire sleep_fall = sleep_pin_d_r && !SLEEP_REQUEST_IN;
  wire irq_fall = irq_pin_d_r && !EXT_IRQ_N_IN;
  wire hold_req = cycle_start && !BUS_REQ_N_IN && !emu_r;
  wire sleep_pin_ok = sleep_fall && (state_r == ST_RUN) && !emu_r;
  wire sleep_instr_done = (sleep_kind_r != chw_pkg::CHW_INSTR_NONE) && cycle_end
                          && (sleep_cnt_r == chw_pkg::CHW_SLEEP_LAST);
  wire irq_take = cycle_start && status_r[chw_pkg::CHW_IP_BIT] && status_r[chw_pkg::CHW_IE_BIT]
                  && (state_r == ST_RUN) && !ack_active_r;
  wire wr_go = aw_held_r && w_held_r && !S_AXI_BVALID;
  wire wr_status = wr_go && (awaddr_r == chw_pkg::CHW_STATUS_OFF);
  wire wr_ctrl = wr_go && (awaddr_r == chw_pkg::CHW_CTRL_OFF);
  wire wr_ok = wr_status || wr_ctrl;
  wire [15:0] wr_mask = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  wire [15:0] status_wr = (status_r & ~wr_mask) | (wdata_r[15:0] & wr_mask);
  wire rd_status = S_AXI_ARADDR == chw_pkg::CHW_STATUS_OFF;
  wire rd_ctrl = S_AXI_ARADDR == chw_pkg::CHW_CTRL_OFF;
  wire rd_state = S_AXI_ARADDR == chw_pkg::CHW_STATE_OFF;
  wire [31:0] rd_word = rd_status ? {16'h0000, status_r} :
                        rd_ctrl ? {30'h00000000, halt_req_r, emu_r} :
                        rd_state ? {25'h0000000, state_r, 1'b0, phase_r, SLEEP_ACK_N_OUT, BUS_GRANT_ACK_N_OUT}
                        : 32'h00000000;

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_RUN:
      begin
        if (hold_req)
          state_nxt = ST_HOLD_PEND;
        else if (sleep_pin_ok)
          state_nxt = ST_SLEEP_PEND;
        else if (sleep_instr_done)
          state_nxt = (sleep_kind_r == chw_pkg::CHW_INSTR_DEEP) ? ST_DEEP : ST_SLEEP;
        else if (emu_r && halt_req_r)
          state_nxt = ST_HALT;
      end
      ST_SLEEP_PEND:
        if (cycle_end)
          state_nxt = ST_SLEEP;
      ST_SLEEP, ST_DEEP:
        if (irq_edge_r)
          state_nxt = ST_RUN;
      ST_HOLD_PEND:
        if (cycle_end)
          state_nxt = BUS_REQ_N_IN ? ST_RUN : ST_HOLD;
      ST_HOLD:
        if (cycle_start && BUS_REQ_N_IN)
          state_nxt = ST_RUN;
      ST_HALT:
        if (!(emu_r && halt_req_r))
          state_nxt = ST_RUN;
      default:
        state_nxt = ST_RUN;
    endcase
  end

  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      state_r <= ST_RUN;
      phase_r <= 1'b0;
      edge_cnt_r <= 2'h0;
    end
    else
    begin
      state_r <= state_nxt;
      if (!clk_run)
      begin
        phase_r <= 1'b0;
        edge_cnt_r <= 2'h0;
      end
      else if (cycle_end)
      begin
        phase_r <= 1'b0;
        edge_cnt_r <= 2'h0;
      end
      else if (stretch)
      begin
        phase_r <= 1'b0;
        edge_cnt_r <= 2'h0;
      end
      else
      begin
        phase_r <= ~phase_r;
        edge_cnt_r <= edge_cnt_r + 2'h1;
      end
    end
  end

  // Edge detectors run on the free clock so wake-up works with the cycle clock stopped
  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      sleep_pin_d_r <= 1'b1;
      irq_pin_d_r <= 1'b1;
      irq_edge_r <= 1'b0;
    end
    else
    begin
      sleep_pin_d_r <= SLEEP_REQUEST_IN;
      irq_pin_d_r <= EXT_IRQ_N_IN;
      irq_edge_r <= irq_fall && !irq_edge_r && !clk_run;
    end
  end

  // Sleep instruction counter; a false condition drops the request
  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      sleep_kind_r <= chw_pkg::CHW_INSTR_NONE;
      sleep_cnt_r <= 2'h0;
    end
    else if (sleep_instr_done || state_r != ST_RUN)
    begin
      sleep_kind_r <= chw_pkg::CHW_INSTR_NONE;
      sleep_cnt_r <= 2'h0;
    end
    else if (sleep_kind_r == chw_pkg::CHW_INSTR_NONE)
    begin
      if (cycle_start && INSTR_COND_IN && (INSTR_SLEEP_IN || INSTR_DEEP_IN))
        sleep_kind_r <= INSTR_DEEP_IN ? chw_pkg::CHW_INSTR_DEEP : chw_pkg::CHW_INSTR_SLEEP;
    end
    else if (cycle_end)
      sleep_cnt_r <= sleep_cnt_r + 2'h1;
  end

  // Status word, handshakes and bus enables
  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      status_r <= chw_pkg::CHW_STATUS_RST;
      emu_r <= 1'b0;
      halt_req_r <= 1'b0;
      hs_r <= '{1'b1, 1'b1, 1'b1, 1'b1};
      oe_r <= '{1'b1, 1'b1, 1'b1};
      ack_active_r <= 1'b0;
      wake_irq_r <= 1'b0;
    end
    else
    begin
      if (wr_status)
        status_r <= status_wr;
      if (wr_ctrl)
      begin
        emu_r <= wdata_r[chw_pkg::CHW_CTRL_EMU_BIT];
        halt_req_r <= wdata_r[chw_pkg::CHW_CTRL_HALT_BIT];
      end
      // Trigger set wins over acknowledge and software clear
      if (irq_take)
        status_r[chw_pkg::CHW_IP_BIT] <= 1'b0;
      if (irq_fall || irq_edge_r)
        status_r[chw_pkg::CHW_IP_BIT] <= 1'b1;
      wake_irq_r <= irq_edge_r && status_r[chw_pkg::CHW_IE_BIT];
      if (irq_take)
      begin
        hs_r.irq_ack_n <= 1'b0;
        ack_active_r <= 1'b1;
      end
      else if (cycle_end && ack_active_r)
      begin
        hs_r.irq_ack_n <= 1'b1;
        ack_active_r <= 1'b0;
      end
      hs_r.irq_done_n <= !(RTI_DONE_IN && clk_run);
      hs_r.sleep_ack_n <= !((state_nxt == ST_SLEEP) || (state_nxt == ST_DEEP));
      hs_r.bus_grant_ack_n <= state_nxt != ST_HOLD;
      oe_r.ibus_oe <= !(state_nxt inside {ST_HOLD_PEND, ST_HOLD, ST_SLEEP, ST_DEEP});
      oe_r.xybus_oe <= !(state_nxt inside {ST_HOLD, ST_SLEEP, ST_DEEP});
      oe_r.addr_ctl_oe <= !(state_nxt inside {ST_HOLD, ST_SLEEP, ST_DEEP});
    end
  end

  // Cycle clock output keeps toggling in light sleep; only deep sleep stops it
  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
      CYCLE_CLOCK_OUT <= 1'b0;
    else if (state_r == ST_DEEP)
      CYCLE_CLOCK_OUT <= 1'b0;
    else
      CYCLE_CLOCK_OUT <= ~CYCLE_CLOCK_OUT;
  end

  assign CYCLE_EN_OUT = cycle_end;
  assign BUS_SWITCH_CLOCK_EN_OUT = clk_run;
  assign XFER_CLOCK_EN_OUT = clk_run;
  assign ALL_CLOCK_EN_OUT = state_r != ST_DEEP;
  assign EXEC_EN_OUT = cycle_end && (state_r == ST_RUN || state_r == ST_SLEEP_PEND
                       || state_r == ST_HOLD_PEND) && !wake_irq_r;
  assign SLEEP_ACK_N_OUT = hs_r.sleep_ack_n;
  assign IRQ_ACK_N_OUT = hs_r.irq_ack_n;
  assign IRQ_DONE_N_OUT = hs_r.irq_done_n;
  assign BUS_GRANT_ACK_N_OUT = hs_r.bus_grant_ack_n;
  assign IBUS_OE_OUT = oe_r.ibus_oe;
  assign XYBUS_OE_OUT = oe_r.xybus_oe;
  assign ADDR_CTL_OE_OUT = oe_r.addr_ctl_oe;

  // AXI4-Lite write side: address and data captured in either order
  assign S_AXI_AWREADY = !aw_held_r;
  assign S_AXI_WREADY = !w_held_r;
  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= chw_pkg::CHW_RESP_OKAY;
    end
    else
    begin
      if (S_AXI_AWVALID && !aw_held_r)
      begin
        aw_held_r <= 1'b1;
        awaddr_r <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !w_held_r)
      begin
        w_held_r <= 1'b1;
        wdata_r <= S_AXI_WDATA;
        wstrb_r <= S_AXI_WSTRB;
      end
      if (wr_go)
      begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_ok ? chw_pkg::CHW_RESP_OKAY : chw_pkg::CHW_RESP_SLVERR;
      end
      else if (S_AXI_BVALID && S_AXI_BREADY)
        S_AXI_BVALID <= 1'b0;
    end
  end

  // Read side: one cycle to data
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= chw_pkg::CHW_RESP_OKAY;
    end
    else if (S_AXI_ARVALID && !S_AXI_RVALID)
    begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_word;
      S_AXI_RRESP <= (rd_status || rd_ctrl || rd_state) ? chw_pkg::CHW_RESP_OKAY : chw_pkg::CHW_RESP_SLVERR;
    end
    else if (S_AXI_RVALID && S_AXI_RREADY)
      S_AXI_RVALID <= 1'b0;
  end
endmodule

//--- tb/chw_far_end.sv
// Far side model: sleep and interrupt sources, bus master and a slow memory.
// Assumes the bench calls pulse and hold, and seeds $urandom.
`timescale 1ns/100ps
module chw_far_end
(
  input wire logic clk_in,
  input wire logic slow_in,
  output logic sleep_request_out,
  output logic ext_irq_n_out,
  output logic bus_req_n_out,
  output logic wait_release_n_out
);
  int wcnt = 0;
  initial
  begin
    sleep_request_out = 1'b1;
    ext_irq_n_out = 1'b1;
    bus_req_n_out = 1'b1;
    wait_release_n_out = 1'b0;
  end
  // Held three clocks so the core sees the falling edge whatever its phase
  task automatic pulse(input logic irq);
    @(posedge clk_in);
    if (irq)
      ext_irq_n_out <= 1'b0;
    else
      sleep_request_out <= 1'b0;
    repeat (3) @(posedge clk_in);
    ext_irq_n_out <= 1'b1;
    sleep_request_out <= 1'b1;
  endtask
  task automatic hold(input logic on);
    @(posedge clk_in);
    bus_req_n_out <= !on;
  endtask
  // Busy bursts of random length, released low when the data is ready
  always @(posedge clk_in)
  begin
    if (wcnt != 0)
      wcnt <= wcnt - 1;
    else if (slow_in)
      wcnt <= $urandom_range(9, 5);
    wait_release_n_out <= slow_in && wcnt > 1;
  end
endmodule

//--- tb/chw_core_control_chk.sv
// Port checker for the core control block.
// Assumes binding to chw_core_control, one clock domain.
`timescale 1ns/100ps
module chw_core_control_chk
(
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic EXT_IRQ_N_IN,
  input wire logic BUS_REQ_N_IN,
  input wire logic WAIT_RELEASE_N_IN,
  input wire logic CYCLE_CLOCK_OUT,
  input wire logic CYCLE_EN_OUT,
  input wire logic BUS_SWITCH_CLOCK_EN_OUT,
  input wire logic XFER_CLOCK_EN_OUT,
  input wire logic ALL_CLOCK_EN_OUT,
  input wire logic EXEC_EN_OUT,
  input wire logic SLEEP_ACK_N_OUT,
  input wire logic IRQ_ACK_N_OUT,
  input wire logic BUS_GRANT_ACK_N_OUT,
  input wire logic IBUS_OE_OUT,
  input wire logic XYBUS_OE_OUT,
  input wire logic ADDR_CTL_OE_OUT
);
  default clocking @(posedge CLK_IN);
  endclocking
  default disable iff (RST_IN);
  AST_HOLD_REL: assert property (!BUS_GRANT_ACK_N_OUT |-> !IBUS_OE_OUT && !XYBUS_OE_OUT && !ADDR_CTL_OE_OUT)
    else $error("Bus driven in hold");
  AST_IBUS_FIRST: assert property ($fell(BUS_GRANT_ACK_N_OUT) |-> $past(!IBUS_OE_OUT))
    else $error("Instruction bus not released first");
  AST_SLEEP_CLK: assert property (!SLEEP_ACK_N_OUT |-> !BUS_SWITCH_CLOCK_EN_OUT && !XFER_CLOCK_EN_OUT && !EXEC_EN_OUT)
    else $error("Clock running in sleep");
  AST_SLEEP_BUS: assert property (!SLEEP_ACK_N_OUT && $past(!SLEEP_ACK_N_OUT) |-> !XYBUS_OE_OUT && !ADDR_CTL_OE_OUT)
    else $error("Bus driven in sleep");
  AST_CYC_OUT: assert property (!SLEEP_ACK_N_OUT && ALL_CLOCK_EN_OUT |=> CYCLE_CLOCK_OUT != $past(CYCLE_CLOCK_OUT))
    else $error("Cycle clock output stopped in light sleep");
  AST_DEEP: assert property (!ALL_CLOCK_EN_OUT |-> !SLEEP_ACK_N_OUT)
    else $error("Clocks off without sleep acknowledge");
  AST_WAKE: assert property ($fell(EXT_IRQ_N_IN) && !SLEEP_ACK_N_OUT |-> ##[1:3] SLEEP_ACK_N_OUT)
    else $error("No wake on interrupt edge");
  AST_ACK_LEN: assert property ($fell(IRQ_ACK_N_OUT) |-> !IRQ_ACK_N_OUT [*2] ##[1:7] IRQ_ACK_N_OUT)
    else $error("Interrupt acknowledge length wrong");
  AST_CYC_GAP: assert property (CYCLE_EN_OUT |=> !CYCLE_EN_OUT)
    else $error("Cycle shorter than two clocks");
  AST_STRETCH: assert property (WAIT_RELEASE_N_IN [*4] |-> !CYCLE_EN_OUT)
    else $error("Cycle ended while wait held");
  AST_HOLD_EXIT: assert property (!BUS_GRANT_ACK_N_OUT && BUS_REQ_N_IN && !WAIT_RELEASE_N_IN |-> ##[1:4] BUS_GRANT_ACK_N_OUT)
    else $error("Hold not left");
endmodule
bind chw_core_control chw_core_control_chk chk_i (.CLK_IN, .RST_IN, .EXT_IRQ_N_IN, .BUS_REQ_N_IN, .WAIT_RELEASE_N_IN,
  .CYCLE_CLOCK_OUT, .CYCLE_EN_OUT, .BUS_SWITCH_CLOCK_EN_OUT, .XFER_CLOCK_EN_OUT, .ALL_CLOCK_EN_OUT, .EXEC_EN_OUT,
  .SLEEP_ACK_N_OUT, .IRQ_ACK_N_OUT, .BUS_GRANT_ACK_N_OUT, .IBUS_OE_OUT, .XYBUS_OE_OUT, .ADDR_CTL_OE_OUT);

//--- tb/core_halt_hold_wait_control_tb.sv
// Self-checking bench for the core control block.
// Assumes chw_far_end on the pins and the bound checker.
`timescale 1ns/100ps
module core_halt_hold_wait_control_tb;
  logic clk = 0, rst = 1, slow = 0, i_s = 0, i_d = 0, cond = 0, rti = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic [3:0] wstrb = 4'hf;
  wire sreq, irq_n, breq_n, wrel_n, cclk, cyc, bs, xf, all_en, ex, slp_n, ack_n, done_n, gnt_n, ib, xy, ac;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  int err_total = 0, samples_checked = 0, n, last;
  logic odd, lng;
  always #2 clk = ~clk;
  chw_far_end far_i (.clk_in(clk), .slow_in(slow), .sleep_request_out(sreq), .ext_irq_n_out(irq_n),
    .bus_req_n_out(breq_n), .wait_release_n_out(wrel_n));
  chw_core_control chw_core_control_i (.CLK_IN(clk), .RST_IN(rst), .SLEEP_REQUEST_IN(sreq), .EXT_IRQ_N_IN(irq_n),
    .BUS_REQ_N_IN(breq_n), .WAIT_RELEASE_N_IN(wrel_n), .INSTR_SLEEP_IN(i_s), .INSTR_DEEP_IN(i_d), .INSTR_COND_IN(cond),
    .RTI_DONE_IN(rti), .CYCLE_CLOCK_OUT(cclk), .CYCLE_EN_OUT(cyc), .BUS_SWITCH_CLOCK_EN_OUT(bs), .XFER_CLOCK_EN_OUT(xf),
    .ALL_CLOCK_EN_OUT(all_en), .EXEC_EN_OUT(ex), .SLEEP_ACK_N_OUT(slp_n), .IRQ_ACK_N_OUT(ack_n),
    .IRQ_DONE_N_OUT(done_n), .BUS_GRANT_ACK_N_OUT(gnt_n), .IBUS_OE_OUT(ib), .XYBUS_OE_OUT(xy), .ADDR_CTL_OE_OUT(ac),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] sts(input logic ie, input logic ip);
    sts = chw_pkg::CHW_STATUS_RST;
    sts[chw_pkg::CHW_IE_BIT] = ie;
    sts[chw_pkg::CHW_IP_BIT] = ip;
  endfunction
  function automatic logic pin(input int s);
    logic [6:0] v;
    v = {cyc, ex, all_en, ack_n, gnt_n, slp_n, done_n};
    return v[s];
  endfunction
  // Bounded wait for a pin level; a miss ends the run
  task automatic wait_pin(input int s, input logic v);
    for (n = 0; n < 60 && pin(s) !== v; n++) @(posedge clk);
    check(pin(s), v);
    if (pin(s) !== v)
      tally_and_finish();
  endtask
  task automatic cnt(input int s, input int k, output int c);
    c = 0;
    repeat (k)
    begin
      @(posedge clk);
      c += pin(s);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 30 && !bvalid; n++)
    begin
      @(posedge clk);
      if (awready)
        awv <= 1'b0;
      if (wready)
        wv <= 1'b0;
    end
    bready <= 1'b0;
    check({bvalid, bresp}, {1'b1, er});
  endtask
  task automatic axr(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 30 && !rvalid; n++)
    begin
      @(posedge clk);
      if (arready)
        arv <= 1'b0;
    end
    rready <= 1'b0;
    check({rvalid, rresp, rdata[15:0] & m}, {1'b1, er, e});
  endtask
  // Holds the decoded instruction up to the next cycle end so it arms once
  task automatic arm(input logic deep, input logic c);
    @(posedge clk);
    i_s <= !deep;
    i_d <= deep;
    cond <= c;
    for (n = 0; n < 8; n++)
    begin
      @(posedge clk);
      if (cyc)
        break;
    end
    i_s <= 1'b0;
    i_d <= 1'b0;
  endtask
  task automatic wake_irq;
    far_i.pulse(1'b1);
    wait_pin(1, 1'b1);
    wait_pin(3, 1'b0);
    wait_pin(3, 1'b1);
  endtask
  initial
  begin
    int c;
    void'($urandom(91438));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    axr(chw_pkg::CHW_STATUS_OFF, 16'hffff, sts(0, 0), chw_pkg::CHW_RESP_OKAY);
    wstrb <= 4'h1;
    axw(chw_pkg::CHW_STATUS_OFF, 32'h0000c04c, chw_pkg::CHW_RESP_OKAY);
    axr(chw_pkg::CHW_STATUS_OFF, 16'hffff, sts(0, 0), chw_pkg::CHW_RESP_OKAY);
    wstrb <= 4'hf;
    axw(8'h0c, $urandom, chw_pkg::CHW_RESP_SLVERR);
    axr(8'h0c, 16'hffff, 16'h0, chw_pkg::CHW_RESP_SLVERR);
    cnt(6, 20, c);
    check(c, 10);
    $display("registers done");
    far_i.hold(1'b1);
    wait_pin(2, 1'b0);
    check({ib, xy, ac}, 3'b000);
    cnt(5, 6, c);
    check(c, 0);
    far_i.hold(1'b0);
    wait_pin(2, 1'b1);
    axw(chw_pkg::CHW_CTRL_OFF, 32'h1, chw_pkg::CHW_RESP_OKAY);
    far_i.hold(1'b1);
    far_i.pulse(1'b0);
    cnt(2, 20, c);
    check(c, 20);
    check(slp_n, 1'b1);
    far_i.hold(1'b0);
    axw(chw_pkg::CHW_CTRL_OFF, 32'h3, chw_pkg::CHW_RESP_OKAY);
    cnt(5, 8, c);
    check(c, 0);
    axw(chw_pkg::CHW_CTRL_OFF, 32'h2, chw_pkg::CHW_RESP_OKAY);
    cnt(5, 8, c);
    check(c > 0, 1'b1);
    axw(chw_pkg::CHW_CTRL_OFF, 32'h0, chw_pkg::CHW_RESP_OKAY);
    $display("hold and halt done");
    far_i.pulse(1'b0);
    wait_pin(1, 1'b0);
    @(posedge clk);
    check({bs, xf, xy, ac, all_en}, 5'b00001);
    far_i.pulse(1'b1);
    wait_pin(1, 1'b1);
    cnt(3, 12, c);
    check(c, 12);
    check(done_n, 1'b1);
    axr(chw_pkg::CHW_STATUS_OFF, 16'h4000, 16'h4000, chw_pkg::CHW_RESP_OKAY);
    axw(chw_pkg::CHW_STATUS_OFF, {16'h0, sts(1, 1)}, chw_pkg::CHW_RESP_OKAY);
    wait_pin(3, 1'b0);
    wait_pin(3, 1'b1);
    axr(chw_pkg::CHW_STATUS_OFF, 16'hc000, 16'h8000, chw_pkg::CHW_RESP_OKAY);
    @(posedge clk);
    rti <= 1'b1;
    repeat (2) @(posedge clk);
    rti <= 1'b0;
    check(done_n, 1'b0);
    $display("sleep pin done");
    arm(1'b0, 1'b0);
    cnt(1, 12, c);
    check(c, 12);
    arm(1'b0, 1'b1);
    wait_pin(1, 1'b0);
    check(n >= 2 * chw_pkg::CHW_SLEEP_INSTR_CYCLES && n <= 2 * chw_pkg::CHW_SLEEP_INSTR_CYCLES + 2, 1'b1);
    wake_irq();
    arm(1'b1, 1'b1);
    wait_pin(4, 1'b0);
    cnt(4, 4, c);
    check(c, 0);
    check({slp_n, cclk}, 2'b00);
    wake_irq();
    $display("sleep instructions done");
    slow <= 1'b1;
    last = -1;
    odd = 0;
    lng = 0;
    for (int i = 0; i < 120; i++)
    begin
      @(posedge clk);
      if (cyc && last >= 0)
      begin
        odd |= (i - last) % 2;
        lng |= (i - last) > 2;
      end
      if (cyc)
        last = i;
    end
    slow <= 1'b0;
    check({odd, lng}, 2'b01);
    $display("wait states done");
    tally_and_finish();
  end
endmodule
